// >>> hw/gpiop_consts.svh
`ifndef GPIOP_CONSTS_SVH
`define GPIOP_CONSTS_SVH

// Register addresses in bank 15, as seen by the core's data-memory port.
`define GPIOP_ADDR_PD_SEL 7'h66
`define GPIOP_ADDR_GRP_DIR 7'h67
`define GPIOP_ADDR_DIR_BASE 7'h50
`define GPIOP_ADDR_DATA_BASE 7'h70
`define GPIOP_ADDR_IN_PD 7'h7C
`define GPIOP_ADDR_IN_A 7'h7D
`define GPIOP_ADDR_IN_C 7'h7E

// Reset values.
`define GPIOP_RST_LATCH 4'h0
`define GPIOP_RST_DIR 4'h0
`define GPIOP_RST_PD_SEL 4'h0

// Field layout: read-back pins are bits 3 and 2 of port 0; stop gating spares 3, 2, 0 of A.
`define GPIOP_RB_MASK 4'hC
`define GPIOP_STOP_KEEP_A 4'hD

`endif

// >>> hw/gpiop_pkg.sv
package gpiop_pkg;

    // Power state of the core as seen by the port logic.
    typedef enum logic [1:0] {
        GPIOP_RUN = 2'b00,
        GPIOP_HALT = 2'b01,
        GPIOP_STOP = 2'b10
    } gpiop_pwr_t;

endpackage

// >>> hw/gpiop_pin_bank.sv
`timescale 1ns/1ps
`include "gpiop_consts.svh"

module gpiop_pin_bank import gpiop_pkg::*; #(
    parameter logic [3:0] RB_MASK = 4'h0
) (
    input wire logic ref_clk, // System clock.
    input wire logic rst, // Power-on reset, async.
    input wire logic soft_clr, // Watchdog/stack reset pulse.
    input wire logic wr_en, // Write strobe for this port register.
    input wire logic rd_en, // Read strobe for this port register.
    input wire logic [3:0] wr_data, // Write data.
    input wire logic [3:0] dir, // Per-pin direction, 1 is output.
    input wire logic [3:0] pin_i, // Pin levels from the pads.
    output logic [3:0] pin_o, // Pad output values.
    output logic [3:0] pin_oe, // Pad output enables.
    output logic [3:0] rd_view // Value a read of this port returns.
);
    logic [3:0] meta_q;
    logic [3:0] lvl_q;
    logic [3:0] latch_q;
    logic [3:0] latch_d;
    logic [3:0] rb_out;
    logic [3:0] plain_out;
    logic cap;

    // Pads are asynchronous; only the second stage is read.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 4'h0;
            lvl_q <= 4'h0;
        end else begin
            meta_q <= pin_i;
            lvl_q <= meta_q;
        end
    end

    // A read-back pin in output mode is overwritten by any read of the port.
    assign rb_out = RB_MASK & dir;
    assign plain_out = dir & ~RB_MASK;
    assign cap = rd_en & (|rb_out);

    // Writes land in the latch regardless of direction; a write outranks capture.
    always_comb begin
        latch_d = latch_q;
        if (soft_clr) begin
            latch_d = `GPIOP_RST_LATCH;
        end else if (wr_en) begin
            latch_d = wr_data;
        end else if (cap) begin
            latch_d = (latch_q & ~rb_out) | (lvl_q & rb_out);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_q <= `GPIOP_RST_LATCH;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Output pins show the latch; input pins float.
    assign pin_o = latch_q;
    assign pin_oe = dir;

    // Plain output pins read the latch, all others read the pad.
    assign rd_view = (plain_out & latch_q) | (~plain_out & lvl_q);
endmodule

// >>> hw/gpiop_top.sv
`timescale 1ns/1ps
`include "gpiop_consts.svh"

// Operation
// - Bit ports set direction per pin.
// - Nibble ports set direction four pins together.
// - Output pins drive their latch value.
// - Written one drives high, zero low.
// - Input pins release the driver.
// - Output-mode reads return latch, not pin, except on read-back pins.
// - Read-back pins always read the pad level.
// - Port read overwrites output read-back latches.
// - Power-on and watchdog reset clear direction, latch, select bits.
// - CE reset and stop keep direction, latch.
// - Halt keeps all port state unchanged.
// - Input port reads give pin levels.
// - Writes to input ports do nothing.
// - Pull-down on when select bit zero.
// - Select register: four bits at 66H.
// - Stop gates floating inputs, three pins spared.
// - Input-mode writes still update the latch.
// - Direction bit one means output.
// - Resets clear select bits, pull-downs on.
// - CE reset and stop keep select bits.

module gpiop_top import gpiop_pkg::*; #(
    parameter int N_BIT = 8,
    parameter int N_GRP = 4
) (
    input wire logic ref_clk, // System clock, 10 MHz.
    input wire logic rst, // Power-on reset, async, active high.
    input wire logic wdt_rst, // Watchdog/stack reset, one-cycle pulse.
    input wire logic halt_req, // Core is halted while high.
    input wire logic stop_exec, // Clock stop executed, one-cycle pulse.
    input wire logic stop_wake, // Leave clock stop, one-cycle pulse.
    input wire logic [6:0] reg_addr, // Bank 15 data address.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    input wire logic [3:0] reg_wdata, // Write data nibble.
    output logic [3:0] reg_rdata, // Read data, valid after a read.
    input wire logic [4*(N_BIT+N_GRP)-1:0] bidir_pin_i, // Pad levels.
    output logic [4*(N_BIT+N_GRP)-1:0] bidir_pin_o, // Pad drive values.
    output logic [4*(N_BIT+N_GRP)-1:0] bidir_pin_oe, // Pad enables.
    input wire logic [3:0] pulldown_input_port_i, // Input port with pull-downs.
    input wire logic [3:0] plain_input_port_a_i, // Plain input port A.
    input wire logic [3:0] plain_input_port_c_i, // Plain input port C.
    output logic [3:0] pulldown_en, // Pull-down connected when high.
    output logic stop_gate // Input gating during clock stop.
);
    localparam int N_PORT = N_BIT + N_GRP;

    gpiop_pwr_t pwr_q;
    gpiop_pwr_t pwr_d;

    logic [3:0] bdir_q [N_BIT];
    logic [3:0] grp_dir_q;
    logic [3:0] pulldown_select_bit_q;
    logic [3:0] rdata_q;
    logic [3:0] rdata_d;

    logic [3:0] port_dir [N_PORT];
    logic [3:0] port_view [N_PORT];
    logic [N_PORT-1:0] hit_data;
    logic [N_BIT-1:0] hit_dir;

    logic acc_ok;
    logic wr_go;
    logic rd_go;
    logic hit_pd;
    logic hit_grp;
    logic hit_in_pd;
    logic hit_in_a;
    logic hit_in_c;
    logic stop_go;
    logic in_stop;
    logic [3:0] data_or [N_PORT+1];
    logic [3:0] dir_or [N_BIT+1];
    logic [3:0] src_grp;
    logic [3:0] src_pd;
    logic [3:0] src_in;

    logic [11:0] in_meta_q;
    logic [11:0] in_lvl_q;
    logic [3:0] in_pd_view;
    logic [3:0] in_a_view;
    logic [3:0] in_c_view;

    // Stop is only taken from a running core; a halted core executes nothing.
    assign stop_go = stop_exec & ~halt_req;
    assign in_stop = (pwr_q == GPIOP_STOP);

    // Power state. Halt and stop freeze software access, so nothing moves.
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            GPIOP_RUN: begin
                if (stop_go) begin
                    pwr_d = GPIOP_STOP;
                end else if (halt_req) begin
                    pwr_d = GPIOP_HALT;
                end
            end
            GPIOP_HALT: begin
                // The halt state trails the request by a cycle, so a stop issued in
                // the first cycle after release must still be taken.
                if (stop_go) begin
                    pwr_d = GPIOP_STOP;
                end else if (!halt_req) begin
                    pwr_d = GPIOP_RUN;
                end
            end
            GPIOP_STOP: begin
                if (stop_wake) begin
                    pwr_d = GPIOP_RUN;
                end
            end
            default: begin
                pwr_d = GPIOP_RUN;
            end
        endcase
    end

    // Watchdog reset returns the state machine to run as the core restarts.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwr_q <= GPIOP_RUN;
        end else if (wdt_rst) begin
            pwr_q <= GPIOP_RUN;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // Accesses count outside stop while the halt request is low; the request level is
    // used rather than the trailing halt state, so no access is lost on release.
    assign acc_ok = !in_stop && !halt_req;
    assign wr_go = reg_wr & acc_ok & ~wdt_rst;
    assign rd_go = reg_rd & acc_ok & ~wdt_rst;

    // Fixed-address decodes.
    assign hit_pd = (reg_addr == `GPIOP_ADDR_PD_SEL);
    assign hit_grp = (reg_addr == `GPIOP_ADDR_GRP_DIR);
    assign hit_in_pd = (reg_addr == `GPIOP_ADDR_IN_PD);
    assign hit_in_a = (reg_addr == `GPIOP_ADDR_IN_A);
    assign hit_in_c = (reg_addr == `GPIOP_ADDR_IN_C);

    // Per-port decode, direction registers and pin banks.
    genvar gi;
    generate
        for (gi = 0; gi < N_PORT; gi++) begin : g_port
            assign hit_data[gi] = (reg_addr == (`GPIOP_ADDR_DATA_BASE + 7'(gi)));
            assign data_or[gi+1] = data_or[gi] | (port_view[gi] & {4{hit_data[gi]}});

            if (gi < N_BIT) begin : g_bit
                assign hit_dir[gi] = (reg_addr == (`GPIOP_ADDR_DIR_BASE + 7'(gi)));
                assign dir_or[gi+1] = dir_or[gi] | (bdir_q[gi] & {4{hit_dir[gi]}});

                // One direction bit per pin; CE reset is not wired here, so it keeps it.
                always_ff @(posedge ref_clk or posedge rst) begin
                    if (rst) begin
                        bdir_q[gi] <= `GPIOP_RST_DIR;
                    end else if (wdt_rst) begin
                        bdir_q[gi] <= `GPIOP_RST_DIR;
                    end else if (wr_go && hit_dir[gi]) begin
                        bdir_q[gi] <= reg_wdata;
                    end
                end

                assign port_dir[gi] = bdir_q[gi];
            end else begin : g_grp
                // One bit fans out to all four pins of the nibble port.
                assign port_dir[gi] = {4{grp_dir_q[gi-N_BIT]}};
            end

            gpiop_pin_bank #(
                .RB_MASK((gi == 0) ? `GPIOP_RB_MASK : 4'h0)
            ) u_bank (
                .ref_clk(ref_clk),
                .rst(rst),
                .soft_clr(wdt_rst),
                .wr_en(wr_go & hit_data[gi]),
                .rd_en(rd_go & hit_data[gi]),
                .wr_data(reg_wdata),
                .dir(port_dir[gi]),
                .pin_i(bidir_pin_i[4*gi +: 4]),
                .pin_o(bidir_pin_o[4*gi +: 4]),
                .pin_oe(bidir_pin_oe[4*gi +: 4]),
                .rd_view(port_view[gi])
            );
        end
    endgenerate

    // Group direction register for the nibble ports.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            grp_dir_q <= `GPIOP_RST_DIR;
        end else if (wdt_rst) begin
            grp_dir_q <= `GPIOP_RST_DIR;
        end else if (wr_go && hit_grp) begin
            grp_dir_q <= reg_wdata;
        end
    end

    // Pull-down selection; survives CE reset and stop because neither touches it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulldown_select_bit_q <= `GPIOP_RST_PD_SEL;
        end else if (wdt_rst) begin
            pulldown_select_bit_q <= `GPIOP_RST_PD_SEL;
        end else if (wr_go && hit_pd) begin
            pulldown_select_bit_q <= reg_wdata;
        end
    end

    // A zero bit connects the resistor.
    assign pulldown_en = ~pulldown_select_bit_q;

    // Input-only pads: two stages before anything looks at them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_meta_q <= 12'h000;
            in_lvl_q <= 12'h000;
        end else begin
            in_meta_q <= {plain_input_port_c_i, plain_input_port_a_i, pulldown_input_port_i};
            in_lvl_q <= in_meta_q;
        end
    end

    // During stop, floating inputs are blocked so noise costs no current.
    // Three pins of port A stay live, since they can serve as wake sources.
    assign stop_gate = in_stop;
    assign in_pd_view = in_lvl_q[3:0] & {4{~stop_gate}};
    assign in_a_view = in_lvl_q[7:4] & ({4{~stop_gate}} | `GPIOP_STOP_KEEP_A);
    assign in_c_view = in_lvl_q[11:8] & {4{~stop_gate}};

    // Read multiplexer. Each source is masked by its own decode and all are ORed, so
    // an unmapped address reads zero. Input-only ports have no write path at all.
    assign data_or[0] = 4'h0;
    assign dir_or[0] = 4'h0;
    assign src_grp = grp_dir_q & {4{hit_grp}};
    assign src_pd = pulldown_select_bit_q & {4{hit_pd}};
    assign src_in = (in_pd_view & {4{hit_in_pd}}) | (in_a_view & {4{hit_in_a}})
        | (in_c_view & {4{hit_in_c}});
    assign rdata_d = data_or[N_PORT] | dir_or[N_BIT] | src_grp | src_pd | src_in;

    // Read data is registered and holds until the next accepted read.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 4'h0;
        end else if (rd_go) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
endmodule

// >>> testbench/gpiop_top_sva.sv
`timescale 1ns/1ps
`include "gpiop_consts.svh"

module gpiop_top_sva #(
    parameter int N_BIT = 8,
    parameter int N_GRP = 4
) (
    input wire logic ref_clk, // Clock.
    input wire logic rst, // Async reset.
    input wire logic wdt_rst, // Watchdog reset.
    input wire logic halt_req, // Halt level.
    input wire logic stop_exec, // Stop pulse.
    input wire logic stop_wake, // Wake pulse.
    input wire logic [6:0] reg_addr, // Address.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    input wire logic [3:0] reg_wdata, // Write data.
    input wire logic [4*(N_BIT+N_GRP)-1:0] bidir_pin_o, // Drive values.
    input wire logic [4*(N_BIT+N_GRP)-1:0] bidir_pin_oe, // Enables.
    input wire logic [3:0] pulldown_en, // Pull-downs.
    input wire logic stop_gate // Stop gating.
);
    logic stop_q;
    logic stop_d;
    logic wr_ok;
    // Stop is tracked so that refused writes are never taken for accepted ones.
    // A stop pulse only counts while the halt request is low.
    assign stop_d = wdt_rst ? 1'b0 : (stop_q ? !stop_wake : (stop_exec && !halt_req));
    assign wr_ok = reg_wr && !wdt_rst && !halt_req && !stop_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_dir;
        wr_ok && reg_addr == `GPIOP_ADDR_DIR_BASE |=> bidir_pin_oe[3:0] == $past(reg_wdata);
    endproperty
    a_dir: assert property (p_dir) else $error("bit direction wrong");
    property p_grp;
        wr_ok && reg_addr == `GPIOP_ADDR_GRP_DIR |=> bidir_pin_oe[4*N_BIT+:4] == {4{$past(reg_wdata[0])}}
            && bidir_pin_oe[4*N_BIT+12+:4] == {4{$past(reg_wdata[3])}};
    endproperty
    a_grp: assert property (p_grp) else $error("group direction wrong");
    property p_latch;
        wr_ok && reg_addr == `GPIOP_ADDR_DATA_BASE |=> bidir_pin_o[3:0] == $past(reg_wdata);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not written");
    property p_pd;
        wr_ok && reg_addr == `GPIOP_ADDR_PD_SEL |=> pulldown_en == ~$past(reg_wdata);
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down wrong");
    property p_in_wr;
        wr_ok && reg_addr inside {7'h7C, 7'h7D, 7'h7E} |=> $stable(bidir_pin_o)
            && $stable(bidir_pin_oe) && $stable(pulldown_en);
    endproperty
    a_in_wr: assert property (p_in_wr) else $error("input write had effect");
    property p_rd_keep;
        reg_rd && !reg_wr && !wdt_rst && reg_addr != `GPIOP_ADDR_DATA_BASE |=> $stable(bidir_pin_o);
    endproperty
    a_rd_keep: assert property (p_rd_keep) else $error("read changed latch");
    property p_wdt;
        wdt_rst |=> bidir_pin_oe == '0 && bidir_pin_o == '0 && pulldown_en == 4'hF;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
    property p_halt;
        halt_req && !wdt_rst |=> $stable(bidir_pin_o) && $stable(bidir_pin_oe) && $stable(pulldown_en);
    endproperty
    a_halt: assert property (p_halt) else $error("halt changed port");
    property p_stop;
        stop_q && !wdt_rst |=> $stable(bidir_pin_o) && $stable(bidir_pin_oe)
            && $stable(pulldown_en);
    endproperty
    a_stop: assert property (p_stop) else $error("stop changed port");
    property p_gate;
        stop_exec && !halt_req && !stop_q && !wdt_rst |=> stop_gate
            ##1 (stop_gate || $past(stop_wake) || $past(wdt_rst));
    endproperty
    a_gate: assert property (p_gate) else $error("stop gate missing");
endmodule

bind gpiop_top gpiop_top_sva #(.N_BIT(N_BIT), .N_GRP(N_GRP)) gpiop_top_sva_inst (
    .ref_clk(ref_clk), .rst(rst), .wdt_rst(wdt_rst), .halt_req(halt_req),
    .stop_exec(stop_exec), .stop_wake(stop_wake), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .bidir_pin_o(bidir_pin_o),
    .bidir_pin_oe(bidir_pin_oe), .pulldown_en(pulldown_en), .stop_gate(stop_gate));

// >>> testbench/gpiop_board.sv
`timescale 1ns/1ps

module gpiop_board (
    input wire logic [47:0] pin_o, // Device drive values.
    input wire logic [47:0] pin_oe, // Device enables.
    input wire logic [47:0] ext_en, // Board drives these pads.
    input wire logic [47:0] ext_v, // Board drive values.
    output logic [47:0] pin_i // Resolved pad levels.
);
    // The board overpowers the device; a floating pad reads the inverse of its latch.
    assign pin_i = (ext_en & ext_v) | (~ext_en & pin_oe & pin_o) | (~ext_en & ~pin_oe & ~pin_o);
endmodule

// >>> testbench/gpiop_top_tb.sv
`timescale 1ns/1ps

module gpiop_top_tb;
    logic ref_clk, rst, wdt_rst, halt_req, stop_exec, stop_wake, reg_wr, reg_rd, stop_gate;
    logic [6:0] reg_addr;
    logic [3:0] reg_wdata, reg_rdata, pd_i, pa_i, pc_i, pulldown_en;
    logic [47:0] pin_i, pin_o, pin_oe, ext_en, ext_v;
    int mismatches, num_checks, cyc;
    gpiop_top gpiop_top_inst (.ref_clk(ref_clk), .rst(rst), .wdt_rst(wdt_rst),
        .halt_req(halt_req), .stop_exec(stop_exec), .stop_wake(stop_wake),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .bidir_pin_i(pin_i), .bidir_pin_o(pin_o),
        .bidir_pin_oe(pin_oe), .pulldown_input_port_i(pd_i), .plain_input_port_a_i(pa_i),
        .plain_input_port_c_i(pc_i), .pulldown_en(pulldown_en), .stop_gate(stop_gate));
    gpiop_board gpiop_board_inst (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_v(ext_v), .pin_i(pin_i));
    // Free-running clock, 100 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // A hung run is cut short and reported as a failure.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Inputs move 10 ns after the edge so the design samples settled values.
    task automatic tick();
        @(posedge ref_clk);
        #10;
    endtask
    task automatic wr(input logic [6:0] a, input logic [3:0] d);
        tick();
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [3:0] exp);
        tick();
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk("reg_rdata", exp, reg_rdata);
    endtask
    initial begin
        {rst, wdt_rst, halt_req, stop_exec, stop_wake, reg_wr, reg_rd} = 7'h40;
        {reg_addr, reg_wdata, ext_en, ext_v} = '0;
        {pd_i, pa_i, pc_i} = 12'h963;
        {mismatches, num_checks, cyc} = '0;
        repeat (12) @(posedge ref_clk);
        #10;
        rst = 1'b0;
        chk("oe", 48'h0, pin_oe);
        chk("pulldown_en", 4'hF, pulldown_en);
        rd(7'h66, 4'h0);
        wr(7'h50, 4'hA);
        chk("oe0", 4'hA, pin_oe[3:0]);
        rd(7'h50, 4'hA);
        wr(7'h70, 4'h6);
        chk("o0", 4'h6, pin_o[3:0]);
        for (int p = 1; p < 8; p++) begin
            wr(7'h50 + 7'(p), 4'h3);
            wr(7'h70 + 7'(p), 4'h9);
            chk("oe", 4'h3, pin_oe[4*p+:4]);
            chk("o", 4'h9, pin_o[4*p+:4]);
        end
        wr(7'h67, 4'h5);
        chk("grp", 16'h0F0F, pin_oe[47:32]);
        rd(7'h67, 4'h5);
        ext_en[7:4] = 4'hF;
        repeat (2) tick();
        rd(7'h71, 4'h1);
        chk("o1", 4'h9, pin_o[7:4]);
        wr(7'h50, 4'hC);
        wr(7'h70, 4'hC);
        ext_en = 48'h4;
        repeat (2) tick();
        rd(7'h70, 4'hB);
        chk("o0", 4'h8, pin_o[3:0]);
        ext_en = '0;
        rd(7'h7C, 4'h9);
        rd(7'h7E, 4'h3);
        wr(7'h7D, 4'hF);
        rd(7'h7D, 4'h6);
        wr(7'h66, 4'hA);
        chk("pulldown_en", 4'h5, pulldown_en);
        rd(7'h66, 4'hA);
        halt_req = 1'b1;
        wr(7'h70, 4'h0);
        halt_req = 1'b0;
        chk("o0", 4'h8, pin_o[3:0]);
        stop_exec = 1'b1;
        tick();
        stop_exec = 1'b0;
        chk("stop_gate", 1'b1, stop_gate);
        wr(7'h66, 4'h0);
        wr(7'h70, 4'h0);
        stop_wake = 1'b1;
        tick();
        stop_wake = 1'b0;
        chk("o0", 4'h8, pin_o[3:0]);
        chk("pulldown_en", 4'h5, pulldown_en);
        wdt_rst = 1'b1;
        tick();
        wdt_rst = 1'b0;
        chk("o", 48'h0, pin_o | pin_oe);
        chk("pulldown_en", 4'hF, pulldown_en);
        complete_run();
    end
endmodule
